// ==== inc/trs_defines.svh ====
/*
 * Constants for the transmitter reset, start-up and block sync logic.
 * Assumes a 250 MHz system clock shared by all transmitters and the controller.
 */
// Functional notes
// - Reset clears state, low power, outputs off
// - Software mode: port live, host configures first
// - Software mode: run bit one starts transmitting
// - Hardware mode: starts automatically after reset release
// - Readable four-bit device identity code
// - Readable four-bit silicon revision code
// - Group shares clock, strobe and reset
// - Strobe aligns channel-status block starts across devices
// - One master drives strobe, others receive
// - External strobe source: all devices slaves
// - Master drives strobe high during first subframe
// - Strobe high three clocks forces block start
// - Direction select high output, low input
// - Positive line output low during reset
`ifndef TRS_DEFINES_SVH
`define TRS_DEFINES_SVH

// ----------------------------------------
// Device register map (index, own port)
// ----------------------------------------
`define TRS_REG_CTRL 2'h0
`define TRS_REG_ID 2'h1
`define TRS_REG_STAT 2'h2
`define TRS_CTRL_RUN_BIT 0
`define TRS_CTRL_RESET 8'h00
`define TRS_ID_CODE 4'h5
`define TRS_REV_CODE 4'h1

// ----------------------------------------
// Framing and timing
// ----------------------------------------
`define TRS_SUBFRAME_CYC 8'h3f
`define TRS_BLOCK_SUBFRAMES 9'h17f
`define TRS_STROBE_MIN_CYC 2'h3

// ----------------------------------------
// Controller APB map (byte addresses)
// ----------------------------------------
`define TRS_APB_CMD 12'h000
`define TRS_APB_WDATA 12'h004
`define TRS_APB_RDATA 12'h008
`define TRS_APB_STAT 12'h00c
`define TRS_CMD_GO_BIT 0
`define TRS_CMD_WR_BIT 1
`define TRS_CMD_RST_BIT 2
`define TRS_CMD_ADDR_LSB 4

`endif

// ==== inc/trs_pkg.sv ====
/*
 * Types for the transmitter reset, start-up and block sync logic.
 * Assumes the defines header is compiled alongside.
 */
`default_nettype none
package trs_pkg;
  typedef enum logic [1:0] {
    TRS_LOW_POWER,
    TRS_RUNNING
  } trs_pwr_e;
  typedef logic [7:0] trs_byte_t;
  typedef logic [1:0] trs_addr_t;
endpackage : trs_pkg
`default_nettype wire

// ==== inc/trs_link_if.sv ====
/*
 * Link between the transmitter and its controller.
 * Assumes both ends run on the shared master clock.
 */
`default_nettype none
interface trs_link_if;
  logic chip_rst_n;
  logic hw_mode;
  logic reg_sel;
  logic reg_wr;
  trs_pkg::trs_addr_t reg_addr;
  trs_pkg::trs_byte_t reg_wdata;
  trs_pkg::trs_byte_t reg_rdata;
  logic block_strobe_dir_sel;
  logic strobe_from_dev;
  logic strobe_oe_dev;
  logic strobe_from_peer;
  logic strobe_oe_peer;
  logic block_start_strobe;
  logic line_out_pos;
  logic line_out_neg;
  assign block_start_strobe = strobe_oe_dev ? strobe_from_dev :
                              (strobe_oe_peer ? strobe_from_peer : 1'b0);
  modport dev (
    input chip_rst_n, hw_mode, reg_sel, reg_wr, reg_addr, reg_wdata,
    input block_strobe_dir_sel, block_start_strobe,
    output reg_rdata, strobe_from_dev, strobe_oe_dev, line_out_pos, line_out_neg
  );
  modport ctl (
    output chip_rst_n, hw_mode, reg_sel, reg_wr, reg_addr, reg_wdata,
    output block_strobe_dir_sel, strobe_from_peer, strobe_oe_peer,
    input reg_rdata, block_start_strobe, line_out_pos, line_out_neg
  );
endinterface : trs_link_if
`default_nettype wire

// ==== hw/trs_device.sv ====
/*
 * Transmitter end: reset and power state, run bit, identity register and
 * channel-status block timing with block-start strobe master or slave.
 * Assumes the clock is the shared master clock and reset_n arrives synchronous.
 */
`default_nettype none
`include "trs_defines.svh"
module trs_device (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  trs_link_if.dev link,
  input wire logic data_bit_in,
  output logic running_out,
  output logic block_start_out
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  trs_pkg::trs_pwr_e pwr_q, pwr_d;
  trs_pkg::trs_byte_t ctrl_q, ctrl_d, rdata_q, rdata_d;
  logic [7:0] sub_cyc_q, sub_cyc_d;
  logic [8:0] sub_cnt_q, sub_cnt_d;
  logic [1:0] hi_cnt_q, hi_cnt_d;
  logic pend_q, pend_d;
  logic strobe_q, strobe_d;
  logic oe_q, oe_d;
  logic pos_q, pos_d;
  logic neg_q, neg_d;
  logic run_q, run_d;
  logic bs_q, bs_d;
  logic in_rst;

  assign in_rst = sys_rst_in | ~link.chip_rst_n;

  function automatic trs_pkg::trs_byte_t rd_mux(input trs_pkg::trs_addr_t a,
                                                input trs_pkg::trs_byte_t c,
                                                input logic r);
    unique case (a)
      `TRS_REG_CTRL: rd_mux = c;
      `TRS_REG_ID: rd_mux = {`TRS_ID_CODE, `TRS_REV_CODE};
      `TRS_REG_STAT: rd_mux = {7'h00, r};
      default: rd_mux = 8'h00;
    endcase
  endfunction : rd_mux

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic frame_end;
    logic blk_end;
    frame_end = 1'b0;
    blk_end = 1'b0;
    pwr_d = pwr_q;
    ctrl_d = ctrl_q;
    rdata_d = rdata_q;
    sub_cyc_d = sub_cyc_q;
    sub_cnt_d = sub_cnt_q;
    hi_cnt_d = hi_cnt_q;
    pend_d = pend_q;
    strobe_d = strobe_q;
    oe_d = link.block_strobe_dir_sel;
    pos_d = pos_q;
    neg_d = neg_q;
    bs_d = 1'b0;
    if (link.reg_sel) begin
      if (link.reg_wr && link.reg_addr == `TRS_REG_CTRL) begin
        ctrl_d = link.reg_wdata;
      end
      rdata_d = rd_mux(link.reg_addr, ctrl_q, pwr_q == trs_pkg::TRS_RUNNING);
    end
    unique case (pwr_q)
      trs_pkg::TRS_LOW_POWER: begin
        pos_d = 1'b0;
        neg_d = 1'b0;
        strobe_d = 1'b0;
        if (link.hw_mode || ctrl_q[`TRS_CTRL_RUN_BIT]) begin
          pwr_d = trs_pkg::TRS_RUNNING;
          sub_cyc_d = 8'h00;
          sub_cnt_d = 9'h000;
          strobe_d = 1'b1;
          bs_d = 1'b1;
        end
      end
      trs_pkg::TRS_RUNNING: begin
        if (!link.hw_mode && !ctrl_q[`TRS_CTRL_RUN_BIT]) begin
          pwr_d = trs_pkg::TRS_LOW_POWER;
        end
        if (!link.block_strobe_dir_sel) begin
          if (link.block_start_strobe) begin
            if (hi_cnt_q != `TRS_STROBE_MIN_CYC) begin
              hi_cnt_d = hi_cnt_q + 2'h1;
            end
            if (hi_cnt_q == `TRS_STROBE_MIN_CYC - 2'h1) begin
              pend_d = 1'b1;
            end
          end else begin
            hi_cnt_d = 2'h0;
          end
        end
        frame_end = (sub_cyc_q == `TRS_SUBFRAME_CYC);
        blk_end = (sub_cnt_q == `TRS_BLOCK_SUBFRAMES);
        sub_cyc_d = frame_end ? 8'h00 : sub_cyc_q + 8'h01;
        if (frame_end) begin
          if (blk_end || pend_q) begin
            sub_cnt_d = 9'h000;
            pend_d = 1'b0;
            bs_d = 1'b1;
          end else begin
            sub_cnt_d = sub_cnt_q + 9'h001;
          end
        end
        strobe_d = frame_end ? (blk_end || pend_q) : (sub_cnt_q == 9'h000);
        pos_d = sub_cyc_q[0] ^ data_bit_in;
        neg_d = ~(sub_cyc_q[0] ^ data_bit_in);
      end
      default: pwr_d = trs_pkg::TRS_LOW_POWER;
    endcase
    run_d = (pwr_d == trs_pkg::TRS_RUNNING);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (in_rst) begin
      pwr_q <= trs_pkg::TRS_LOW_POWER;
      ctrl_q <= `TRS_CTRL_RESET;
      rdata_q <= 8'h00;
      sub_cyc_q <= 8'h00;
      sub_cnt_q <= 9'h000;
      hi_cnt_q <= 2'h0;
      pend_q <= 1'b0;
      strobe_q <= 1'b0;
      oe_q <= 1'b0;
      pos_q <= 1'b0;
      neg_q <= 1'b0;
      run_q <= 1'b0;
      bs_q <= 1'b0;
    end else if (clk_en_in) begin
      pwr_q <= pwr_d;
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
      sub_cyc_q <= sub_cyc_d;
      sub_cnt_q <= sub_cnt_d;
      hi_cnt_q <= hi_cnt_d;
      pend_q <= pend_d;
      strobe_q <= strobe_d;
      oe_q <= oe_d;
      pos_q <= pos_d;
      neg_q <= neg_d;
      run_q <= run_d;
      bs_q <= bs_d;
    end
  end

  assign link.reg_rdata = rdata_q;
  assign link.strobe_from_dev = strobe_q;
  assign link.strobe_oe_dev = oe_q;
  assign link.line_out_pos = pos_q;
  assign link.line_out_neg = neg_q;
  assign running_out = run_q;
  assign block_start_out = bs_q;
endmodule : trs_device
`default_nettype wire

// ==== hw/trs_ctrl.sv ====
/*
 * Controller end: APB slave that drives chip reset, mode, register accesses
 * and an optional external block-start strobe.
 * Assumes the transmitter shares clk_in and answers register reads next cycle.
 */
`default_nettype none
`include "trs_defines.svh"
module trs_ctrl (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hw_mode_in,
  input wire logic strobe_master_in,
  input wire logic ext_strobe_in,
  trs_link_if.ctl link
);
  logic [31:0] prdata_q, prdata_d;
  logic [2:0] cmd_q, cmd_d;
  logic [1:0] addr_q, addr_d;
  trs_pkg::trs_byte_t wdata_q, wdata_d, rdata_q, rdata_d;
  logic rst_n_q, rst_n_d, sel_q, sel_d, wr_q, wr_d, busy_q, busy_d, cap_q, cap_d;
  logic strobe_q, strobe_d, oe_q, oe_d, dir_q, dir_d, hw_q, hw_d;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic acc;
    acc = psel & penable;
    prdata_d = prdata_q;
    cmd_d = cmd_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = cap_q ? link.reg_rdata : rdata_q;
    cap_d = 1'b0;
    sel_d = 1'b0;
    wr_d = wr_q;
    busy_d = cap_q ? 1'b0 : busy_q;
    rst_n_d = rst_n_q;
    hw_d = hw_mode_in;
    dir_d = strobe_master_in;
    oe_d = ~strobe_master_in;
    strobe_d = ext_strobe_in;
    if (sel_q) begin
      cap_d = 1'b1;
    end
    if (acc && pwrite) begin
      unique case (paddr)
        `TRS_APB_CMD: begin
          rst_n_d = ~pwdata[`TRS_CMD_RST_BIT];
          if (pwdata[`TRS_CMD_GO_BIT] && !busy_q) begin
            sel_d = 1'b1;
            wr_d = pwdata[`TRS_CMD_WR_BIT];
            addr_d = pwdata[`TRS_CMD_ADDR_LSB +: 2];
            busy_d = 1'b1;
          end
          cmd_d = pwdata[2:0];
        end
        `TRS_APB_WDATA: wdata_d = pwdata[7:0];
        default: wdata_d = wdata_q;
      endcase
    end
    if (acc && !pwrite) begin
      unique case (paddr)
        `TRS_APB_CMD: prdata_d = {29'h0, cmd_q};
        `TRS_APB_WDATA: prdata_d = {24'h0, wdata_q};
        `TRS_APB_RDATA: prdata_d = {24'h0, rdata_q};
        `TRS_APB_STAT: prdata_d = {28'h0, link.line_out_pos, link.block_start_strobe,
                                   ~rst_n_q, busy_q};
        default: prdata_d = 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      prdata_q <= 32'h0;
      cmd_q <= 3'h0;
      addr_q <= 2'h0;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
      rst_n_q <= 1'b0;
      sel_q <= 1'b0;
      wr_q <= 1'b0;
      busy_q <= 1'b0;
      cap_q <= 1'b0;
      strobe_q <= 1'b0;
      oe_q <= 1'b0;
      dir_q <= 1'b0;
      hw_q <= 1'b0;
    end else if (clk_en_in) begin
      prdata_q <= prdata_d;
      cmd_q <= cmd_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      rst_n_q <= rst_n_d;
      sel_q <= sel_d;
      wr_q <= wr_d;
      busy_q <= busy_d;
      cap_q <= cap_d;
      strobe_q <= strobe_d;
      oe_q <= oe_d;
      dir_q <= dir_d;
      hw_q <= hw_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign link.chip_rst_n = rst_n_q;
  assign link.hw_mode = hw_q;
  assign link.reg_sel = sel_q;
  assign link.reg_wr = wr_q;
  assign link.reg_addr = addr_q;
  assign link.reg_wdata = wdata_q;
  assign link.block_strobe_dir_sel = dir_q;
  assign link.strobe_from_peer = strobe_q;
  assign link.strobe_oe_peer = oe_q;
endmodule : trs_ctrl
`default_nettype wire

// ==== verif/trs_link_asserts.sv ====
/* Checker on the link between controller and transmitter.
   Assumes the bench instantiates it beside the link, clocked by clk_in. */
`default_nettype none
`include "trs_defines.svh"
module trs_link_asserts (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic chip_rst_n,
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire trs_pkg::trs_addr_t reg_addr,
  input wire trs_pkg::trs_byte_t reg_wdata,
  input wire trs_pkg::trs_byte_t reg_rdata,
  input wire logic block_strobe_dir_sel,
  input wire logic strobe_from_dev,
  input wire logic strobe_oe_dev,
  input wire logic strobe_oe_peer,
  input wire logic line_out_pos
);
  // ----------------
  // Helpers
  // ----------------
  logic [7:0] hi_cnt_q;
  logic [7:0] hi_cnt_d;
  logic run_set_q;
  logic run_set_d;
  always_comb begin
    hi_cnt_d = (strobe_oe_dev && strobe_from_dev) ? hi_cnt_q + 8'h01 : 8'h00;
    run_set_d = run_set_q;
    if (!chip_rst_n) begin
      run_set_d = 1'b0;
    end else if (reg_sel && reg_wr && reg_addr == `TRS_REG_CTRL) begin
      run_set_d = reg_wdata[0];
    end
  end
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      hi_cnt_q <= 8'h00;
      run_set_q <= 1'b0;
    end else begin
      hi_cnt_q <= hi_cnt_d;
      run_set_q <= run_set_d;
    end
  end
  // ----------------
  // Properties
  // ----------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_held_rst;
    !chip_rst_n && !$past(chip_rst_n);
  endsequence
  sequence s_ctrl_rd;
    reg_sel && !reg_wr && reg_addr == `TRS_REG_CTRL && chip_rst_n;
  endsequence
  sequence s_id_rd;
    reg_sel && !reg_wr && reg_addr == `TRS_REG_ID && chip_rst_n;
  endsequence
  AST_RST_LINE: assert property (
    s_held_rst |-> !line_out_pos) else $error("line output high in reset");
  AST_RST_OE: assert property (
    s_held_rst |-> !strobe_oe_dev) else $error("strobe driven in reset");
  AST_RST_RDATA: assert property (
    s_held_rst |-> reg_rdata == 8'h00) else $error("read data not clear in reset");
  AST_DIR_IN: assert property (
    !block_strobe_dir_sel |-> !strobe_oe_dev) else $error("strobe driven as input");
  AST_DIR_OUT: assert property (
    chip_rst_n && $past(chip_rst_n) && block_strobe_dir_sel && $past(block_strobe_dir_sel)
    |-> strobe_oe_dev) else $error("strobe not driven as output");
  AST_ID_READ: assert property (
    s_id_rd |=> reg_rdata == {`TRS_ID_CODE, `TRS_REV_CODE}) else $error("bad id read");
  AST_RUN_RST: assert property (
    s_ctrl_rd ##0 !run_set_q |=> !reg_rdata[0]) else $error("run bit set unasked");
  AST_MASTER_HI: assert property (
    strobe_oe_dev && chip_rst_n && $fell(strobe_from_dev)
    |-> hi_cnt_q == `TRS_SUBFRAME_CYC + 8'h01) else $error("strobe width wrong");
  AST_ONE_DRV: assert property (
    strobe_oe_dev |-> !strobe_oe_peer) else $error("two strobe drivers");
endmodule : trs_link_asserts
`default_nettype wire

// ==== verif/testbench.sv ====
/* Self-checking bench: controller and transmitter joined by the link.
   Assumes design files, link and checker are compiled first. */
`default_nettype none
`include "trs_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, data_bit_in = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, running_out, block_start_out;
  logic hw_mode_in = 1'b0, strobe_master_in = 1'b1, ext_strobe_in = 1'b0;
  logic [7:0] exp_q[$];
  int failures = 0, cmp_count = 0, cyc = 0, n;
  event ev_rd;
  trs_link_if lnk();
  always #2 clk_in = ~clk_in;
  trs_ctrl trs_ctrl_i (.clk_in, .sys_rst_in, .clk_en_in(1'b1), .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .hw_mode_in, .strobe_master_in,
    .ext_strobe_in, .link(lnk));
  trs_device trs_device_i (.clk_in, .sys_rst_in, .clk_en_in(1'b1), .link(lnk),
    .data_bit_in, .running_out, .block_start_out);
  trs_link_asserts trs_link_asserts_i (.clk_in, .sys_rst_in, .chip_rst_n(lnk.chip_rst_n),
    .reg_sel(lnk.reg_sel), .reg_wr(lnk.reg_wr), .reg_addr(lnk.reg_addr),
    .reg_wdata(lnk.reg_wdata), .reg_rdata(lnk.reg_rdata),
    .block_strobe_dir_sel(lnk.block_strobe_dir_sel), .strobe_from_dev(lnk.strobe_from_dev),
    .strobe_oe_dev(lnk.strobe_oe_dev), .strobe_oe_peer(lnk.strobe_oe_peer),
    .line_out_pos(lnk.line_out_pos));
  // ----------------
  // Tasks
  // ----------------
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task summarize;
    if (failures == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_in);
    @(negedge clk_in);
  endtask : apb
  task dev(input logic w, input logic [1:0] a, input logic [7:0] d);
    int k;
    if (w) begin
      apb(1'b1, `TRS_APB_WDATA, {24'h0, d});
    end
    apb(1'b1, `TRS_APB_CMD, {26'h0, a, 2'b00, w, 1'b1});
    k = 0;
    do begin
      apb(1'b0, `TRS_APB_STAT, 32'h0);
      k++;
    end while (prdata[0] !== 1'b0 && k < 20);
    check({31'h0, prdata[0]}, 32'h0, "busy");
    if (!w) begin
      exp_q.push_back(d);
      apb(1'b0, `TRS_APB_RDATA, 32'h0);
      ->ev_rd;
    end
  endtask : dev
  task wait_for(input logic bs, input int lim, output int t);
    t = 0;
    do begin
      @(negedge clk_in);
      t++;
    end while ((bs ? block_start_out : running_out) !== 1'b1 && t < lim);
  endtask : wait_for
  // ----------------
  // Monitor, stimulus
  // ----------------
  always @(ev_rd) check({24'h0, prdata[7:0]}, {24'h0, exp_q.pop_front()}, "reg read");
  always @(posedge clk_in) begin
    data_bit_in <= 1'($urandom);
    cyc++;
    if (cyc == 90000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    n = $urandom(32'h5351);
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(negedge clk_in);
    check(running_out, 0, "running_out");
    apb(1'b1, `TRS_APB_CMD, 32'h0);
    dev(1'b0, `TRS_REG_CTRL, `TRS_CTRL_RESET);
    dev(1'b0, `TRS_REG_ID, {`TRS_ID_CODE, `TRS_REV_CODE});
    check(running_out, 0, "running_out");
    dev(1'b1, `TRS_REG_CTRL, 8'h01);
    wait_for(1'b0, 50, n);
    check(running_out, 1, "running_out");
    dev(1'b0, `TRS_REG_CTRL, 8'h01);
    wait_for(1'b1, 25000, n);
    wait_for(1'b1, 25000, n);
    check(n, (32'(`TRS_BLOCK_SUBFRAMES) + 1) * (32'(`TRS_SUBFRAME_CYC) + 1), "period");
    apb(1'b1, `TRS_APB_CMD, 32'h4);
    @(posedge clk_in);
    strobe_master_in <= 1'b0;
    hw_mode_in <= 1'b1;
    repeat (3) @(negedge clk_in);
    check(lnk.line_out_pos, 0, "line_out_pos");
    check(running_out, 0, "running_out");
    apb(1'b1, `TRS_APB_CMD, 32'h0);
    wait_for(1'b0, 50, n);
    check(running_out, 1, "running_out");
    dev(1'b0, `TRS_REG_CTRL, `TRS_CTRL_RESET);
    wait_for(1'b1, 25000, n);
    repeat (1 + $urandom % 40) @(posedge clk_in);
    ext_strobe_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    ext_strobe_in <= 1'b0;
    wait_for(1'b1, 200, n);
    check(block_start_out, 0, "short strobe");
    @(posedge clk_in);
    ext_strobe_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    ext_strobe_in <= 1'b0;
    wait_for(1'b1, 80, n);
    check(block_start_out, 1, "slave block start");
    summarize();
  end
endmodule : testbench
`default_nettype wire
